// File: rtl/amtg_pkg.sv
// Package with transfer encodings and constants for the bus master transfer generator.
package amtg_pkg;
    // ------------------------------------------------------------------
    // Transfer type encodings.
    // ------------------------------------------------------------------
    localparam logic [1:0] AMTG_TR_IDLE = 2'h0;   // No transfer wanted.
    localparam logic [1:0] AMTG_TR_BUSY = 2'h1;   // Pause inside a burst.
    localparam logic [1:0] AMTG_TR_NSEQ = 2'h2;   // First beat or single.
    localparam logic [1:0] AMTG_TR_SEQ = 2'h3;    // Later beat of a burst.
    // ------------------------------------------------------------------
    // Burst encodings.
    // ------------------------------------------------------------------
    localparam logic [2:0] AMTG_BU_SINGLE = 3'h0; // Single transfer.
    localparam logic [2:0] AMTG_BU_INCR = 3'h1;   // Undefined length.
    localparam logic [2:0] AMTG_BU_INCR4 = 3'h3;  // Four beats.
    localparam logic [2:0] AMTG_BU_INCR8 = 3'h5;  // Eight beats.
    // ------------------------------------------------------------------
    // Request kinds from the core and caches.
    // ------------------------------------------------------------------
    localparam logic [2:0] AMTG_K_SINGLE = 3'h0;  // Uncached single load or store.
    localparam logic [2:0] AMTG_K_MULTI = 3'h1;   // Uncached load or store multiple.
    localparam logic [2:0] AMTG_K_WBHALF = 3'h2;  // Dirty half-line write-back.
    localparam logic [2:0] AMTG_K_WBFULL = 3'h3;  // Dirty full-line write-back.
    localparam logic [2:0] AMTG_K_LINE = 3'h4;    // Cache linefetch.
    localparam logic [2:0] AMTG_K_HFETCH = 3'h5;  // Uncached 16-bit instruction fetch.
    // ------------------------------------------------------------------
    // Sizes, counts and reset values.
    // ------------------------------------------------------------------
    localparam logic [2:0] AMTG_SIZE_WORD = 3'h2; // Word transfer size code.
    localparam logic [31:0] AMTG_WORD_BYTES = 32'h4; // Address step per beat.
    localparam int AMTG_KB_BIT = 10;              // Address bit of 1KB boundary.
    localparam logic [3:0] AMTG_LINE_BEATS = 4'h8; // Beats of a linefetch.
    localparam logic [3:0] AMTG_HALF_BEATS = 4'h4; // Beats of a half-line write-back.
    localparam logic [31:0] AMTG_LINE_MASK = 32'hffff_ffe0; // Eight-word alignment.
    localparam logic [31:0] AMTG_HALF_MASK = 32'hffff_fff0; // Four-word alignment.
    localparam logic [1:0] AMTG_LINE_GAP = 2'h1;  // Idle cycles after a linefetch.
    localparam logic [31:0] AMTG_RST_ADDR = 32'h0; // Address after reset.
endpackage : amtg_pkg

// File: rtl/amtg_master.sv
// Bus master transfer generator turning core and cache requests into bus transfers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Owned bus without transfer drives IDLE.
// - BUSY shows next beat address and control.
// - BUSY may pause uncached multiple reads and writes.
// - Singles and first beats are NONSEQ.
// - Later beats SEQ, same control, address stepped.
// - Load/store multiple use INCR bursts.
// - Half write-back INCR4, full and linefetch INCR8.
// - Incrementing bursts step four bytes.
// - Linefetch is eight aligned words.
// - Linefetch request drops when grant seen.
// - IDLE cycles between back-to-back linefetches.
// - Uncached singles use SINGLE, fetches nonsequential.
// - Bursts restart NONSEQ at 1KB boundary.
// - Halfword fetches read words, latch both halves.
// - Address and control hold while ready low.
module amtg_master
    import amtg_pkg::*;
(
    input wire logic i_ref_clk,         // Bus clock, 40 MHz.
    input wire logic i_sys_rst,         // Synchronous reset, active high.
    input wire logic i_req_valid,       // Request pending from core or caches.
    input wire logic [2:0] i_req_kind,  // Request kind code.
    input wire logic i_req_write,       // Request writes when high.
    input wire logic [31:0] i_req_addr, // Request start address.
    input wire logic [4:0] i_req_beats, // Beats of a multiple transfer.
    input wire logic i_req_pause,       // Source not ready for next multiple beat.
    output logic o_req_ready,           // Request taken this cycle.
    output logic [31:0] o_wdata_addr,   // Address whose write data is due.
    output logic o_beat_done,           // Data phase completed at the last edge.
    output logic [31:0] o_rdata,        // Read data of the completed beat.
    output logic [15:0] o_half_instr,   // Halfword instruction for the core.
    output logic o_half_valid,          // Halfword instruction valid pulse.
    input wire logic i_hgrant,          // Bus grant from arbiter.
    output logic o_hbusreq,             // Bus request to arbiter.
    output logic [1:0] o_htrans,        // Transfer type.
    output logic [31:0] o_haddr,        // Transfer address.
    output logic [2:0] o_hburst,        // Burst encoding.
    output logic [2:0] o_hsize,         // Transfer size.
    output logic o_hwrite,              // Write when high.
    input wire logic i_hready,          // Transfer done when high.
    input wire logic [31:0] i_hrdata    // Read data from slave.
);
    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AMTG_S_IDLE = 2'b00,  // No transfer in progress.
        AMTG_S_REQ = 2'b01,   // Waiting for the grant.
        AMTG_S_ADDR = 2'b10,  // Issuing beats.
        AMTG_S_GAP = 2'b11    // Idle gap after a linefetch.
    } amtg_state_t;

    typedef struct packed {
        amtg_state_t st;     // Sequencer state.
        logic busreq;        // Bus request level.
        logic [1:0] trans;   // Driven transfer type.
        logic [31:0] addr;   // Driven address.
        logic [2:0] burst;   // Driven burst code.
        logic write;         // Driven direction.
        logic [4:0] left;    // Beats still to issue.
        logic [2:0] kind;    // Kind of current request.
        logic dvalid;        // A data phase is outstanding.
        logic [31:0] daddr;  // Address of the data phase.
        logic dwrite;        // Direction of the data phase.
        logic done;          // Beat finished pulse.
        logic [31:0] rdata;  // Captured read word.
        logic [31:0] hword;  // Latched word for halfword fetches.
        logic hword_ok;      // Latched word is usable.
        logic hvalid;        // Halfword ready pulse.
        logic [15:0] half;   // Halfword instruction.
        logic hupper;        // Fetch wants the upper halfword of its word.
        logic [1:0] gap;     // Idle gap counter.
    } amtg_regs_t;

    amtg_regs_t r;       // Registered state.
    amtg_regs_t next_r;  // Next state.

    // Next beat address with a one-word step.
    function automatic logic [31:0] amtg_step(input logic [31:0] a);
        amtg_step = a + AMTG_WORD_BYTES;
    endfunction

    // Whether an address lies at the start of a 1KB block.
    function automatic logic amtg_kb_start(input logic [31:0] a);
        amtg_kb_start = (a[AMTG_KB_BIT-1:0] == '0);
    endfunction

    // ------------------------------------------------------------------
    // Combinational next state.
    // ------------------------------------------------------------------
    // Advances the pipeline only when ready is high, so that the address
    // phase of the next transfer stays put during wait states.
    always_comb begin
        logic hit;
        logic [31:0] na;
        hit = 1'b0;
        na = '0;
        next_r = r;
        next_r.done = 1'b0;
        next_r.hvalid = 1'b0;
        o_req_ready = 1'b0;
        if (i_hready) begin
            // Data phase completes; the address phase moves into it.
            if (r.dvalid) begin
                next_r.done = 1'b1;
                next_r.rdata = i_hrdata;
                if (r.kind == AMTG_K_HFETCH) begin
                    next_r.hword = i_hrdata;
                    next_r.hword_ok = 1'b1;
                    next_r.hvalid = 1'b1;
                    next_r.half = r.hupper ? i_hrdata[31:16] : i_hrdata[15:0];
                end
            end
            next_r.dvalid = r.trans[1];
            next_r.daddr = r.addr;
            next_r.dwrite = r.write;
            next_r.trans = AMTG_TR_IDLE;
            unique case (r.st)
                AMTG_S_IDLE: begin
                    next_r.burst = AMTG_BU_SINGLE;
                    // Waits out the last data phase, so a fetch sees the word it latches.
                    if (i_req_valid && !r.dvalid) begin
                        // Halfword fetch hitting the latched word needs no bus.
                        hit = (i_req_kind == AMTG_K_HFETCH) && r.hword_ok &&
                              (i_req_addr[31:2] == r.daddr[31:2]);
                        o_req_ready = 1'b1;
                        if (hit) begin
                            next_r.hvalid = 1'b1;
                            next_r.half = i_req_addr[1] ? r.hword[31:16] : r.hword[15:0];
                        end else begin
                            next_r.st = AMTG_S_REQ;
                            next_r.busreq = 1'b1;
                            next_r.kind = i_req_kind;
                            next_r.write = i_req_write;
                            next_r.addr = i_req_addr;
                            next_r.hword_ok = 1'b0;  // Any bus access makes the latch stale.
                            next_r.left = 5'h1;
                            next_r.burst = AMTG_BU_SINGLE;
                            unique case (i_req_kind)
                                AMTG_K_MULTI: begin
                                    next_r.burst = AMTG_BU_INCR;
                                    next_r.left = i_req_beats;
                                end
                                AMTG_K_WBHALF: begin
                                    next_r.burst = AMTG_BU_INCR4;
                                    next_r.addr = i_req_addr & AMTG_HALF_MASK;
                                    next_r.left = {1'b0, AMTG_HALF_BEATS};
                                end
                                AMTG_K_WBFULL, AMTG_K_LINE: begin
                                    next_r.burst = AMTG_BU_INCR8;
                                    next_r.addr = i_req_addr & AMTG_LINE_MASK;
                                    next_r.left = {1'b0, AMTG_LINE_BEATS};
                                end
                                AMTG_K_HFETCH: begin
                                    next_r.addr = {i_req_addr[31:2], 2'b00};
                                    next_r.hupper = i_req_addr[1];
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                AMTG_S_REQ: begin
                    if (i_hgrant) begin
                        next_r.busreq = 1'b0;
                        next_r.st = AMTG_S_ADDR;
                        next_r.trans = AMTG_TR_NSEQ;
                        next_r.left = r.left - 5'h1;
                    end
                end
                AMTG_S_ADDR: begin
                    na = amtg_step(r.addr);
                    if (r.left == 5'h0) begin
                        next_r.st = (r.kind == AMTG_K_LINE) ? AMTG_S_GAP : AMTG_S_IDLE;
                        next_r.gap = AMTG_LINE_GAP;
                    end else if (!i_hgrant) begin
                        // Lost ownership mid burst: request again, restart NONSEQ.
                        next_r.st = AMTG_S_REQ;
                        next_r.busreq = 1'b1;
                        next_r.addr = (r.trans == AMTG_TR_BUSY) ? r.addr : na;
                    end else if (r.kind == AMTG_K_MULTI && i_req_pause) begin
                        // Pause shows the next beat already.
                        next_r.trans = AMTG_TR_BUSY;
                        next_r.addr = (r.trans == AMTG_TR_BUSY) ? r.addr : na;
                    end else begin
                        next_r.addr = (r.trans == AMTG_TR_BUSY) ? r.addr : na;
                        next_r.left = r.left - 5'h1;
                        // A new 1KB block opens a fresh burst.
                        next_r.trans = amtg_kb_start(next_r.addr) ?
                                       AMTG_TR_NSEQ : AMTG_TR_SEQ;
                    end
                end
                AMTG_S_GAP: begin
                    // Idle gap lets the cache look up the next line.
                    next_r.gap = r.gap - 2'h1;
                    if (r.gap == 2'h1) begin
                        next_r.st = AMTG_S_IDLE;
                    end
                end
            endcase
        end
        if (i_sys_rst) begin
            next_r = '0;
            next_r.st = AMTG_S_IDLE;
            next_r.addr = AMTG_RST_ADDR;
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    // Registers the whole state on every rising edge.
    always_ff @(posedge i_ref_clk) begin
        r <= next_r;
    end

    // Outputs straight from registers, except size, which is tied to the word code.
    assign o_hbusreq = r.busreq;
    assign o_htrans = r.trans;
    assign o_haddr = r.addr;
    assign o_hburst = r.burst;
    assign o_hsize = AMTG_SIZE_WORD;
    assign o_hwrite = r.write;
    assign o_wdata_addr = r.daddr;
    assign o_beat_done = r.done;
    assign o_rdata = r.rdata;
    assign o_half_instr = r.half;
    assign o_half_valid = r.hvalid;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    sequence amtg_wait_s;
        o_htrans[1] && !i_hready;
    endsequence

    AST_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        amtg_wait_s |=> $stable(o_haddr) && $stable(o_htrans) && $stable(o_hburst))
        else $error("Address phase changed during wait state.");

    AST_SEQ_STEP: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_htrans == AMTG_TR_SEQ) && i_hready ##1 (o_htrans == AMTG_TR_SEQ)
        |-> o_haddr == $past(o_haddr) + AMTG_WORD_BYTES && $stable(o_hburst))
        else $error("Sequential beat address or control wrong.");

    AST_KB: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_htrans == AMTG_TR_SEQ) |-> !amtg_kb_start(o_haddr))
        else $error("Sequential beat crosses 1KB boundary.");

    AST_BUSY: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_htrans == AMTG_TR_BUSY) |-> o_hburst == AMTG_BU_INCR)
        else $error("Busy outside an incrementing burst.");

    AST_GRANT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_hbusreq && i_hgrant && i_hready |=> !o_hbusreq && o_htrans == AMTG_TR_NSEQ)
        else $error("Request not dropped on grant.");

    AST_LINE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_htrans == AMTG_TR_NSEQ) && (o_hburst == AMTG_BU_INCR8)
        |-> o_haddr[4:0] == 5'h0)
        else $error("Line burst not line aligned.");

    AST_GAP: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (r.st == AMTG_S_GAP) |-> o_htrans == AMTG_TR_IDLE)
        else $error("No idle gap after linefetch.");

    AST_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (r.st == AMTG_S_IDLE) ##1 (r.st == AMTG_S_IDLE) |-> o_htrans == AMTG_TR_IDLE)
        else $error("Transfer driven with no request.");

    AST_SINGLE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_htrans == AMTG_TR_NSEQ) && (r.kind == AMTG_K_HFETCH || r.kind == AMTG_K_SINGLE)
        |-> o_hburst == AMTG_BU_SINGLE)
        else $error("Single access with burst code.");

endmodule // amtg_master
`default_nettype wire

// File: tb/amtg_bus_model.sv
// Behavioural arbiter and slave standing on the far side of the bus master.
`timescale 1ns/1ps
`default_nettype none
module amtg_bus_model
    import amtg_pkg::*;
(
    input wire logic i_ref_clk,        // Bus clock.
    input wire logic i_sys_rst,        // Synchronous reset, active high.
    input wire logic i_slow,           // Insert one wait state per real beat.
    input wire logic i_hbusreq,        // Bus request from the master.
    input wire logic [1:0] i_htrans,   // Transfer type from the master.
    input wire logic [31:0] i_haddr,   // Address from the master.
    output logic o_hgrant,             // Grant to the master.
    output logic o_hready,             // Data phase done when high.
    output logic [31:0] o_hrdata       // Read data to the master.
);
    // ------------------------------------------------------------------
    // Arbiter and data phase tracking.
    // ------------------------------------------------------------------
    logic [1:0] dtrans; // Transfer type now in its data phase.
    logic [31:0] daddr; // Address now in its data phase.
    logic waited;       // The current data phase already had its wait state.
    // Grant follows the request and stays while the master still moves beats.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_hgrant <= 1'b0;
            dtrans <= AMTG_TR_IDLE;
            daddr <= 32'h0;
            waited <= 1'b0;
        end else begin
            o_hgrant <= i_hbusreq | (i_htrans != AMTG_TR_IDLE);
            waited <= ~o_hready;
            if (o_hready) begin
                dtrans <= i_htrans;
                daddr <= i_haddr;
            end
        end
    end
    // Only real beats are stretched; IDLE and BUSY always finish at once.
    assign o_hready = ~(i_slow & dtrans[1] & ~waited);
    // Outside a finishing beat the data lines show the inverse, never a stale word.
    assign o_hrdata = (o_hready & dtrans[1]) ? (daddr ^ 32'h5a5a_c3c3) : ~(daddr ^ 32'h5a5a_c3c3);
endmodule // amtg_bus_model
`default_nettype wire

// File: tb/amtg_master_tb.sv
// Self-checking testbench for the bus master transfer generator.
`timescale 1ns/1ps
`default_nettype none
module amtg_master_tb
    import amtg_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals, queues and counters.
    // ------------------------------------------------------------------
    logic clk, rst, valid, wr, pause, slow, req_ready, beat_done, half_valid;
    logic hgrant, hbusreq, hwrite, hready, prevr, lastline, pend;
    logic [2:0] kind, hburst, hsize;
    logic [1:0] htrans;
    logic [4:0] beats;
    logic [15:0] half_instr;
    logic [31:0] addr, wdata_addr, rdata, haddr, hrdata, pa;
    logic [40:0] cur, prevc, e;
    logic [40:0] qb[$]; // Expected address phases.
    logic [32:0] qd[$]; // Expected data phases, write flag on top.
    logic [15:0] qh[$]; // Expected halfword instructions.
    int err_total = 0, compares = 0, nbusy = 0, gap = 0;
    assign cur = {htrans, hburst, hsize, hwrite, haddr};
    amtg_master amtg_master_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_req_valid(valid),
        .i_req_kind(kind), .i_req_write(wr), .i_req_addr(addr), .i_req_beats(beats),
        .i_req_pause(pause), .o_req_ready(req_ready), .o_wdata_addr(wdata_addr),
        .o_beat_done(beat_done), .o_rdata(rdata), .o_half_instr(half_instr),
        .o_half_valid(half_valid), .i_hgrant(hgrant), .o_hbusreq(hbusreq), .o_htrans(htrans),
        .o_haddr(haddr), .o_hburst(hburst), .o_hsize(hsize), .o_hwrite(hwrite),
        .i_hready(hready), .i_hrdata(hrdata));
    amtg_bus_model amtg_bus_model_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_slow(slow),
        .i_hbusreq(hbusreq), .i_htrans(htrans), .i_haddr(haddr), .o_hgrant(hgrant),
        .o_hready(hready), .o_hrdata(hrdata));
    // ------------------------------------------------------------------
    // Compare, expectation and request tasks.
    // ------------------------------------------------------------------
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_beat(input logic [40:0] got, input logic [40:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Notes one address phase and its data phase; read words follow the slave's pattern.
    task automatic exp_beat(input logic [1:0] t, input logic [2:0] b, input logic w,
                            input logic [31:0] a);
        qb.push_back({t, b, AMTG_SIZE_WORD, w, a});
        qd.push_back({w, a ^ 32'h5a5a_c3c3});
    endtask
    // Holds the request until ready is seen at a falling edge, then through the next rising edge.
    task automatic req(input logic [2:0] k, input logic w, input logic [31:0] a,
                       input logic [4:0] n);
        logic ok;
        ok = 1'b0;
        // Lets an edge pass so the strobe is low between two requests.
        @(posedge clk);
        #1;
        kind = k;
        wr = w;
        addr = a;
        beats = n;
        valid = 1'b1;
        for (int i = 0; i < 500 && !ok; i++) begin
            @(negedge clk);
            ok = req_ready;
            @(posedge clk);
            #1;
        end
        valid = 1'b0;
    endtask
    // Waits a bounded time for every noted result to appear.
    task automatic settle(input string name);
        for (int i = 0; i < 300 && (qb.size() + qd.size() + qh.size()) != 0; i++)
            @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
        cmp_word(32'(qb.size() + qd.size() + qh.size()), 32'h0);
        $display("test %s done with slow slave %0d", name, slow);
    endtask
    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic run_suite();
        logic [31:0] a, d;
        for (int i = 0; i < 4; i++) begin
            a = $urandom & 32'hffff_fffc;
            exp_beat(AMTG_TR_NSEQ, AMTG_BU_SINGLE, i[0], a);
            req(AMTG_K_SINGLE, i[0], a, 5'h1);
        end
        settle("single");
        // Multiple loads and stores crossing a 1KB boundary, paused in mid-burst.
        for (int w = 0; w < 2; w++) begin
            nbusy = 0;
            a = ($urandom & 32'hffff_fc00) | 32'h3f0;
            for (int i = 0; i < 6; i++)
                exp_beat((i == 0 || i == 4) ? AMTG_TR_NSEQ : AMTG_TR_SEQ, AMTG_BU_INCR,
                         w[0], a + 32'(4 * i));
            req(AMTG_K_MULTI, w[0], a, 5'h6);
            repeat (2) @(posedge clk);
            #1 pause = 1'b1;
            repeat (3) @(posedge clk);
            #1 pause = 1'b0;
            settle("multiple");
            cmp_word(32'(nbusy != 0), 32'h1);
        end
        // Half and full write-backs, then two back-to-back linefetches.
        for (int j = 0; j < 4; j++) begin
            a = $urandom & ((j == 0) ? AMTG_HALF_MASK : AMTG_LINE_MASK);
            for (int i = 0; i < ((j == 0) ? 4 : 8); i++)
                exp_beat(i ? AMTG_TR_SEQ : AMTG_TR_NSEQ, j ? AMTG_BU_INCR8 : AMTG_BU_INCR4,
                         j < 2, a + 32'(4 * i));
            req((j == 0) ? AMTG_K_WBHALF : (j == 1) ? AMTG_K_WBFULL : AMTG_K_LINE, j < 2,
                a | 32'hc, 5'h0);
        end
        settle("line");
        // Halfword fetches: one word read serves two halves, the next word is read anew.
        a = $urandom & 32'hffff_fffc;
        for (int i = 0; i < 2; i++) begin
            d = (a + 32'(4 * i)) ^ 32'h5a5a_c3c3;
            exp_beat(AMTG_TR_NSEQ, AMTG_BU_SINGLE, 1'b0, a + 32'(4 * i));
            if (i == 0) qh.push_back(d[31:16]);
            qh.push_back(d[15:0]);
        end
        req(AMTG_K_HFETCH, 1'b0, a | 32'h2, 5'h1);
        req(AMTG_K_HFETCH, 1'b0, a, 5'h1);
        req(AMTG_K_HFETCH, 1'b0, a + 32'h4, 5'h1);
        settle("halfword");
    endtask
    // ------------------------------------------------------------------
    // Monitor: takes the oldest note whenever a result shows mid-cycle.
    // ------------------------------------------------------------------
    always @(negedge clk) begin
        if (rst) begin
            prevr = 1'b1;
            lastline = 1'b0;
            pend = 1'b0;
        end else begin
            if (!prevr) cmp_beat(cur, prevc);
            // The beat accepted at the last edge is now in its data phase.
            if (pend) cmp_word(wdata_addr, pa);
            pend = 1'b0;
            if (hready && htrans == AMTG_TR_BUSY && qb.size() != 0) begin
                nbusy++;
                cmp_word(haddr, qb[0][31:0]);
            end
            if (hready && htrans == AMTG_TR_IDLE) gap++;
            if (hready && htrans[1]) begin
                e = (qb.size() != 0) ? qb.pop_front() : '1;
                cmp_beat(cur, e);
                pend = 1'b1;
                pa = e[31:0];
                if (e[38:36] == AMTG_BU_INCR8 && !e[32] && e[40:39] == AMTG_TR_NSEQ) begin
                    cmp_word({31'h0, hbusreq}, 32'h0);
                    if (lastline) cmp_word(32'(gap != 0), 32'h1);
                end
                lastline = (e[38:36] == AMTG_BU_INCR8) && !e[32];
                gap = 0;
            end
            if (beat_done && qd.size() != 0 && !qd[0][32]) cmp_word(rdata, qd[0][31:0]);
            if (beat_done && qd.size() != 0) void'(qd.pop_front());
            if (half_valid) cmp_word({16'h0, half_instr}, {16'h0, (qh.size() != 0) ?
                qh.pop_front() : 16'hdead});
            prevr = hready;
            prevc = cur;
        end
    end
    // ------------------------------------------------------------------
    // Clock, main sequence, watchdog and verdict.
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {valid, wr, pause, slow, kind, addr, beats} = '0;
        void'($urandom(32'ha751));
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            run_suite();
        end
        cmp_word({30'h0, htrans}, {30'h0, AMTG_TR_IDLE});
        close_out();
    end
    initial begin
        #500000;
        err_total++;
        close_out();
    end
endmodule // amtg_master_tb
`default_nettype wire
